/* File: hdl/nfc_regs.svh */
// nand flash host controller constants and timing counts
// Notes on behaviour
// - commands, addresses, data share one 8-bit two-way bus, latches decide meaning
// - host marks the end of each 512-byte segment of read data on seg_end_o
// - host refuses a fifth program of the last programmed page between erases; only that one page is counted
// - host ends every cached read with the final read command
// - host ends single plane cache program with serial input then confirm
// - after a cache confirm end, host polls status bit 6 then resets
// - multi plane cache program ends with second plane input then confirm
// - host loads columns 0 to 4351 only, never drives while device outputs
`ifndef NFC_REGS_SVH
`define NFC_REGS_SVH
// ==========
// command bytes
`define NFC_CMD_READ1      8'h00
`define NFC_CMD_READ2      8'h30
`define NFC_CMD_RC_SEQ     8'h31
`define NFC_CMD_RC_END     8'h3F
`define NFC_CMD_LOAD       8'h80
`define NFC_CMD_LOAD_P2    8'h81
`define NFC_CMD_PGM        8'h10
`define NFC_CMD_PGM_CACHE  8'h15
`define NFC_CMD_ERASE1     8'h60
`define NFC_CMD_ERASE2     8'hD0
`define NFC_CMD_STATUS     8'h70
`define NFC_CMD_RESET      8'hFF
// ==========
// geometry and status
`define NFC_PAGE_BYTES     14'h1100
`define NFC_SEG_LAST       9'h1FF
`define NFC_STAT_READY_BIT 6
`define NFC_PGM_LIMIT      3'h4
// ==========
// timing
`define NFC_CLK_NS                  8
`define NFC_ARRAY_TO_BUFFER_TIME_NS 25000
`define NFC_ARRAY_TO_BUFFER_CYC     (`NFC_ARRAY_TO_BUFFER_TIME_NS / `NFC_CLK_NS)
`define NFC_PROG_TIME_US            700
`define NFC_BLOCK_ERASE_TIME_US     5000
`define NFC_RESET_TIME_US           500
`define NFC_WE_TO_BUSY_TIME_NS      100
`define NFC_WAIT_BUSY_CYC           ((`NFC_WE_TO_BUSY_TIME_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS + 2)
`define NFC_WR_LOW                  4'h2
`define NFC_WR_LAST                 4'h9
`define NFC_RD_LOW_FIRST            4'h1
`define NFC_RD_LOW_END              4'h6
`define NFC_RD_LAST                 4'h8
`endif

/* File: hdl/nfc_pkg.sv */
// types of the nand flash host controller
`default_nettype none
package nfc_pkg;
  typedef enum logic [2:0] {
    OP_RESET = 3'h0, OP_STATUS = 3'h1, OP_READ = 3'h2, OP_RC_SEQ = 3'h3,
    OP_RC_END = 3'h4, OP_PROG = 3'h5, OP_PROG_CACHE = 3'h6, OP_ERASE = 3'h7
  } nfc_op_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_CMD1 = 4'h1, S_ADDR = 4'h3, S_DATA_IN = 4'h2, S_CMD2 = 4'h6,
    S_WAIT_B = 4'h7, S_WAIT_R = 4'h5, S_DATA_OUT = 4'h4,
    S_POLL_CMD = 4'hC, S_POLL_RD = 4'hD, S_RST_CMD = 4'hF
  } nfc_state_t;
  typedef struct packed {
    nfc_op_t     op;
    logic        plane2;
    logic [12:0] col;
    logic [18:0] row;
    logic [12:0] len;
  } nfc_req_t;
  typedef struct packed {
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       re_n;
    logic [7:0] io;
    logic       io_oe;
  } nfc_pins_t;
endpackage : nfc_pkg
`default_nettype wire

/* File: hdl/nfc_host.sv */
// nand flash host controller: op sequencer, pin cycles, busy waits
`include "nfc_regs.svh"
`default_nettype none
module nfc_host #(
  parameter int unsigned PROG_CYC  = `NFC_PROG_TIME_US * 1000 / `NFC_CLK_NS,
  parameter int unsigned ERASE_CYC = `NFC_BLOCK_ERASE_TIME_US * 1000 / `NFC_CLK_NS,
  parameter int unsigned RESET_CYC = `NFC_RESET_TIME_US * 1000 / `NFC_CLK_NS
) (
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  // operation request
  input  wire logic              req_valid_i,
  input  wire nfc_pkg::nfc_req_t req_i,
  output var  logic              req_ready_o,
  // program data
  input  wire logic [7:0]        wr_data_i,
  input  wire logic              wr_valid_i,
  output var  logic              wr_ready_o,
  // read data and completion
  output var  logic [7:0]        rd_data_o,
  output var  logic              rd_valid_o,
  output var  logic              seg_end_o,
  output var  logic [7:0]        status_o,
  output var  logic              done_o,
  output var  logic              err_o,
  // flash pins
  output var  nfc_pkg::nfc_pins_t pins_o,
  input  wire logic [7:0]        io_in_i,
  input  wire logic              ready_busy_n_i
);
  nfc_pkg::nfc_state_t state;
  nfc_pkg::nfc_req_t   cur;
  logic [12:0] cnt;
  logic [8:0]  seg;
  logic [4:0]  wcnt;
  logic [19:0] to_cnt;
  logic [19:0] to_lim;
  logic        rec;
  logic        cyc_on, cyc_rd, cyc_cle, cyc_ale;
  logic [7:0]  cyc_byte;
  logic [3:0]  ph;
  logic        rb_s1, rb_s2;
  logic [7:0]  io_s1, io_s2;
  logic        rc_act, cache_pend;
  logic [18:0] last_row;
  logic [2:0]  pgm_cnt;
  logic        acc, refuse, cyc_last;

  // ==========
  // helpers
  function automatic logic is_pgm(input nfc_pkg::nfc_op_t op);
    return op == nfc_pkg::OP_PROG || op == nfc_pkg::OP_PROG_CACHE;
  endfunction : is_pgm

  function automatic logic is_rc(input nfc_pkg::nfc_op_t op);
    return op == nfc_pkg::OP_RC_SEQ || op == nfc_pkg::OP_RC_END;
  endfunction : is_rc

  function automatic logic [19:0] lim_of(input nfc_pkg::nfc_op_t op);
    case (op)
      nfc_pkg::OP_READ, nfc_pkg::OP_RC_SEQ, nfc_pkg::OP_RC_END: return 20'(`NFC_ARRAY_TO_BUFFER_CYC);
      nfc_pkg::OP_PROG, nfc_pkg::OP_PROG_CACHE: return 20'(PROG_CYC);
      nfc_pkg::OP_ERASE: return 20'(ERASE_CYC);
      default: return 20'(RESET_CYC);
    endcase
  endfunction : lim_of

  function automatic logic [7:0] cmd_first(input nfc_pkg::nfc_req_t r);
    case (r.op)
      nfc_pkg::OP_RESET: return `NFC_CMD_RESET;
      nfc_pkg::OP_STATUS: return `NFC_CMD_STATUS;
      nfc_pkg::OP_READ: return `NFC_CMD_READ1;
      nfc_pkg::OP_RC_SEQ: return `NFC_CMD_RC_SEQ;
      nfc_pkg::OP_RC_END: return `NFC_CMD_RC_END;
      nfc_pkg::OP_ERASE: return `NFC_CMD_ERASE1;
      default: return r.plane2 ? `NFC_CMD_LOAD_P2 : `NFC_CMD_LOAD;
    endcase
  endfunction : cmd_first

  function automatic logic [7:0] cmd_second(input nfc_pkg::nfc_req_t r);
    case (r.op)
      nfc_pkg::OP_READ: return `NFC_CMD_READ2;
      nfc_pkg::OP_PROG_CACHE: return `NFC_CMD_PGM_CACHE;
      nfc_pkg::OP_ERASE: return `NFC_CMD_ERASE2;
      default: return `NFC_CMD_PGM;
    endcase
  endfunction : cmd_second

  // erase sends row bytes only: whole block, page bits ignored by the device
  function automatic logic [7:0] addr_byte(input nfc_pkg::nfc_req_t r, input logic [12:0] n);
    logic [12:0] i;
    i = (r.op == nfc_pkg::OP_ERASE) ? n + 13'h2 : n;
    case (i)
      13'h0: return r.col[7:0];
      13'h1: return {3'h0, r.col[12:8]};
      13'h2: return r.row[7:0];
      13'h3: return r.row[15:8];
      default: return {5'h0, r.row[18:16]};
    endcase
  endfunction : addr_byte

  task automatic issue(input logic rd, input logic [7:0] b, input logic c, input logic a);
    cyc_on   <= 1'b1;
    cyc_rd   <= rd;
    cyc_byte <= b;
    cyc_cle  <= c;
    cyc_ale  <= a;
  endtask : issue

  assign acc = req_valid_i && req_ready_o;
  assign refuse = (rc_act && !is_rc(req_i.op))
    || ((req_i.op == nfc_pkg::OP_READ || is_pgm(req_i.op))
        && ({1'b0, req_i.col} + {1'b0, req_i.len}) > `NFC_PAGE_BYTES)
    || (is_pgm(req_i.op) && (req_i.len == 13'h0
        || (req_i.row == last_row && pgm_cnt == `NFC_PGM_LIMIT)));
  assign cyc_last = cyc_on && ph == (cyc_rd ? `NFC_RD_LAST : `NFC_WR_LAST);

  // ==========
  // pin synchronisers
  always_ff @(posedge core_clk_i) begin
    rb_s1 <= ready_busy_n_i;
    rb_s2 <= rb_s1;
    io_s1 <= io_in_i;
    io_s2 <= io_s1;
  end

  // ==========
  // byte cycle phase
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || !cyc_on || cyc_last) begin
      ph <= 4'h0;
    end else begin
      ph <= ph + 4'h1;
    end
  end

  // ==========
  // pins; bus driven only in write cycles, so never while the device outputs
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pins_o <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1, io: 8'h00, io_oe: 1'b0};
    end else begin
      pins_o.ce_n  <= state == nfc_pkg::S_IDLE && !acc;
      pins_o.cle   <= cyc_on && cyc_cle;
      pins_o.ale   <= cyc_on && cyc_ale;
      pins_o.we_n  <= !(cyc_on && !cyc_rd && ph < `NFC_WR_LOW);
      pins_o.re_n  <= !(cyc_on && cyc_rd && ph >= `NFC_RD_LOW_FIRST && ph <= `NFC_RD_LOW_END);
      pins_o.io    <= cyc_byte;
      pins_o.io_oe <= cyc_on && !cyc_rd;
    end
  end

  // ==========
  // sequence flags and partial program tracking (last page only, no table)
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rc_act     <= 1'b0;
      cache_pend <= 1'b0;
      last_row   <= 19'h0_0000;
      pgm_cnt    <= 3'h0;
    end else if (acc && !refuse) begin
      if (req_i.op == nfc_pkg::OP_RC_SEQ) begin
        rc_act <= 1'b1;
      end
      if (req_i.op == nfc_pkg::OP_RC_END) begin
        rc_act <= 1'b0;
      end
      if (req_i.op == nfc_pkg::OP_PROG_CACHE) begin
        cache_pend <= 1'b1;
      end else if (req_i.op == nfc_pkg::OP_PROG) begin
        cache_pend <= 1'b0;
      end
      if (is_pgm(req_i.op)) begin
        last_row <= req_i.row;
        pgm_cnt  <= (req_i.row == last_row) ? pgm_cnt + 3'h1 : 3'h1;
      end
      if (req_i.op == nfc_pkg::OP_ERASE && req_i.row[18:6] == last_row[18:6]) begin
        pgm_cnt <= 3'h0;
      end
    end else if (state == nfc_pkg::S_WAIT_R && rec && rb_s2) begin
      cache_pend <= 1'b0;
    end
  end

  // ==========
  // operation sequencer
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state <= nfc_pkg::S_IDLE;
      cur <= '0;
      {cnt, seg, wcnt, to_cnt, to_lim, rec} <= '0;
      {cyc_on, cyc_rd, cyc_cle, cyc_ale, cyc_byte} <= '0;
      {req_ready_o, wr_ready_o, rd_valid_o, seg_end_o, done_o, err_o} <= '0;
      rd_data_o <= 8'h00;
      status_o <= 8'h00;
    end else begin
      done_o <= 1'b0;
      err_o <= 1'b0;
      rd_valid_o <= 1'b0;
      seg_end_o <= 1'b0;
      if (cyc_last) begin
        cyc_on <= 1'b0;
      end
      case (state)
        nfc_pkg::S_IDLE: begin
          req_ready_o <= !acc;
          if (acc) begin
            cur <= req_i;
            cnt <= 13'h0;
            seg <= 9'h0;
            to_lim <= lim_of(req_i.op);
            if (refuse) begin
              err_o <= 1'b1;
            end else if (cache_pend && !is_pgm(req_i.op)) begin
              rec <= 1'b1;
              to_lim <= 20'(PROG_CYC);
              state <= nfc_pkg::S_POLL_CMD;
            end else begin
              state <= nfc_pkg::S_CMD1;
            end
          end
        end
        nfc_pkg::S_CMD1: begin
          if (!cyc_on) begin
            issue(1'b0, cmd_first(cur), 1'b1, 1'b0);
          end
          if (cyc_last) begin
            case (cur.op)
              nfc_pkg::OP_STATUS: begin
                cur.len <= 13'h1;
                state <= nfc_pkg::S_DATA_OUT;
              end
              nfc_pkg::OP_RESET, nfc_pkg::OP_RC_SEQ, nfc_pkg::OP_RC_END: begin
                wcnt <= 5'h0;
                state <= nfc_pkg::S_WAIT_B;
              end
              default: state <= nfc_pkg::S_ADDR;
            endcase
          end
        end
        nfc_pkg::S_ADDR: begin
          if (!cyc_on) begin
            issue(1'b0, addr_byte(cur, cnt), 1'b0, 1'b1);
          end
          if (cyc_last) begin
            cnt <= cnt + 13'h1;
            if (cnt == ((cur.op == nfc_pkg::OP_ERASE) ? 13'h2 : 13'h4)) begin
              cnt <= 13'h0;
              state <= is_pgm(cur.op) ? nfc_pkg::S_DATA_IN : nfc_pkg::S_CMD2;
            end
          end
        end
        nfc_pkg::S_DATA_IN: begin
          if (!cyc_on) begin
            wr_ready_o <= !(wr_ready_o && wr_valid_i);
            if (wr_ready_o && wr_valid_i) begin
              issue(1'b0, wr_data_i, 1'b0, 1'b0);
            end
          end
          if (cyc_last) begin
            cnt <= cnt + 13'h1;
            if (cnt == cur.len - 13'h1) begin
              state <= nfc_pkg::S_CMD2;
            end
          end
        end
        nfc_pkg::S_CMD2, nfc_pkg::S_RST_CMD: begin
          if (!cyc_on) begin
            issue(1'b0, state == nfc_pkg::S_RST_CMD ? `NFC_CMD_RESET : cmd_second(cur), 1'b1, 1'b0);
          end
          if (cyc_last) begin
            if (state == nfc_pkg::S_RST_CMD) begin
              to_lim <= 20'(RESET_CYC);
            end
            wcnt <= 5'h0;
            state <= nfc_pkg::S_WAIT_B;
          end
        end
        // busy may only show after the write edge plus synchroniser delay
        nfc_pkg::S_WAIT_B: begin
          wcnt <= wcnt + 5'h1;
          if (wcnt == 5'(`NFC_WAIT_BUSY_CYC)) begin
            to_cnt <= 20'h0_0000;
            state <= nfc_pkg::S_WAIT_R;
          end
        end
        nfc_pkg::S_WAIT_R: begin
          to_cnt <= to_cnt + 20'h1;
          if (rb_s2) begin
            cnt <= 13'h0;
            if (rec) begin
              rec <= 1'b0;
              to_lim <= lim_of(cur.op);
              state <= nfc_pkg::S_CMD1;
            end else if ((cur.op == nfc_pkg::OP_READ || is_rc(cur.op)) && cur.len != 13'h0) begin
              state <= nfc_pkg::S_DATA_OUT;
            end else begin
              done_o <= 1'b1;
              state <= nfc_pkg::S_IDLE;
            end
          end else if (to_cnt == to_lim) begin
            err_o <= 1'b1;
            rec <= 1'b0;
            state <= nfc_pkg::S_IDLE;
          end
        end
        // sample before the strobe rises: works for both release styles
        nfc_pkg::S_DATA_OUT: begin
          if (!cyc_on) begin
            issue(1'b1, 8'h00, 1'b0, 1'b0);
          end
          if (cyc_last) begin
            rd_data_o <= io_s2;
            rd_valid_o <= 1'b1;
            seg <= seg + 9'h1;
            seg_end_o <= seg == `NFC_SEG_LAST;
            if (cur.op == nfc_pkg::OP_STATUS) begin
              status_o <= io_s2;
            end
            cnt <= cnt + 13'h1;
            if (cnt == cur.len - 13'h1) begin
              done_o <= 1'b1;
              state <= nfc_pkg::S_IDLE;
            end
          end
        end
        nfc_pkg::S_POLL_CMD: begin
          if (!cyc_on) begin
            issue(1'b0, `NFC_CMD_STATUS, 1'b1, 1'b0);
          end
          if (cyc_last) begin
            to_cnt <= 20'h0_0000;
            state <= nfc_pkg::S_POLL_RD;
          end
        end
        nfc_pkg::S_POLL_RD: begin
          to_cnt <= to_cnt + 20'h1;
          if (!cyc_on) begin
            issue(1'b1, 8'h00, 1'b0, 1'b0);
          end
          if (cyc_last) begin
            status_o <= io_s2;
            if (io_s2[`NFC_STAT_READY_BIT]) begin
              state <= nfc_pkg::S_RST_CMD;
            end else if (to_cnt >= to_lim) begin
              err_o <= 1'b1;
              rec <= 1'b0;
              state <= nfc_pkg::S_IDLE;
            end
          end
        end
        default: state <= nfc_pkg::S_IDLE;
      endcase
    end
  end

  // ==========
  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  latch_excl_a: assert property (pins_o.cle |-> !pins_o.ale && pins_o.io_oe) else $error("latch clash");
  no_drive_read_a: assert property (!pins_o.re_n |-> !pins_o.io_oe) else $error("bus driven in read");
  col_span_a: assert property (state == nfc_pkg::S_DATA_IN |-> ({1'b0, cur.col} + {1'b0, cnt}) < `NFC_PAGE_BYTES)
    else $error("column past page");
  pgm_limit_a: assert property (pgm_cnt <= `NFC_PGM_LIMIT) else $error("page programmed too often");
  rc_refuse_a: assert property (acc && rc_act && !is_rc(req_i.op) |=> err_o && state == nfc_pkg::S_IDLE)
    else $error("cached read not ended");
  cache_recover_a: assert property (acc && !refuse && cache_pend && !is_pgm(req_i.op) |=> state == nfc_pkg::S_POLL_CMD)
    else $error("no recovery after cache program");
  seg_mark_a: assert property (seg_end_o |-> rd_valid_o && $past(seg) == `NFC_SEG_LAST) else $error("segment mark");
  busy_timeout_a: assert property (state == nfc_pkg::S_WAIT_R && !rb_s2 && to_cnt == to_lim |=> err_o)
    else $error("busy wait overrun");
  cmd_strobe_a: assert property ($fell(pins_o.we_n) && pins_o.cle |-> pins_o.cle [*2] ##1 pins_o.we_n)
    else $error("command strobe");

  read_done_c: cover property (state == nfc_pkg::S_DATA_OUT && done_o);
  prog_done_c: cover property (state == nfc_pkg::S_WAIT_R && rb_s2 && is_pgm(cur.op));
  recover_c: cover property (state == nfc_pkg::S_RST_CMD ##[1:40] state == nfc_pkg::S_WAIT_B);
endmodule : nfc_host
`default_nettype wire

/* File: tb/nfc_flash_model.sv */
// behavioural model of the flash device on the far side of the host pins
`default_nettype none
module nfc_flash_model (
  // pins from host
  input  wire nfc_pkg::nfc_pins_t pins_i,
  input  wire logic               slow_i,
  // pins to host
  output var  logic [7:0]         io_o,
  output var  logic               ready_busy_n_o,
  output var  logic [7:0]         resets_o
);
  timeunit 1ns;
  timeprecision 100ps;
  typedef logic [7:0] nfc_page_t [0:4351];
  nfc_page_t  mem [int]; // every block, block 0 included, starts usable
  nfc_page_t  pbuf;
  logic [7:0] adr [0:4];
  int         na, col, row, mode; // mode 0 read, 1 status, 2 program, 3 erase
  logic       oe;
  initial begin
    io_o = 8'h5A;
    ready_busy_n_o = 1'b1;
    resets_o = 8'h00;
    oe = 1'b0;
    {na, col, row, mode} = '0;
  end
  // ==========
  // busy and commands
  // one documented microsecond lasts one ns here, 40 ns while slow_i is set, so runs stay short
  task automatic busy(int us);
    ready_busy_n_o = 1'b0;
    ready_busy_n_o <= #(slow_i ? us * 40 : us) 1'b1;
  endtask : busy
  task automatic command(logic [7:0] c);
    case (c)
      8'h00, 8'h60: begin na = 0; mode = c[6] ? 3 : 0; end
      8'h80, 8'h81: begin na = 0; mode = 2; foreach (pbuf[i]) pbuf[i] = 8'hFF; end
      8'h30, 8'h31, 8'h3F: begin
        if (c != 8'h30) begin row++; col = 0; end
        if (mem.exists(row)) pbuf = mem[row];
        else foreach (pbuf[i]) pbuf[i] = 8'hFF;
        busy(25);
      end
      8'h10, 8'h15: begin
        if (!mem.exists(row)) mem[row] = '{default: 8'hFF};
        foreach (pbuf[i]) mem[row][i] &= pbuf[i];
        busy((c[2] || !ready_busy_n_o) ? 700 : 300);
      end
      8'hD0: begin
        for (int p = 0; p < 64; p++) mem.delete({row[18:6], 6'(p)});
        busy(2500);
      end
      8'h3A: busy(30);
      8'h11: busy(10);
      8'h70: mode = 1;
      8'hFF: begin
        resets_o++;
        busy(ready_busy_n_o ? 5 : (mode == 3) ? 500 : (mode == 2) ? 10 : 5);
        mode = 0;
      end
      default: ;
    endcase
  endtask : command
  // ==========
  // byte latching on write strobe rise
  always @(posedge pins_i.we_n) if (!pins_i.ce_n) begin
    if (pins_i.cle) command(pins_i.io);
    else if (pins_i.ale && na < 5) begin
      adr[na] = pins_i.io;
      na++;
      if (mode == 3 && na == 3) row = {adr[2], adr[1], adr[0]};
      if (mode != 3 && na == 5) begin col = {adr[1], adr[0]}; row = {adr[4], adr[3], adr[2]}; end
    end else if (!pins_i.ale && col < 4352) begin
      pbuf[col] = pins_i.io;
      col++;
    end
  end
  // ==========
  // data output and release
  always @(negedge pins_i.re_n) if (!pins_i.ce_n) begin
    #5 oe = 1'b1;
    io_o = (mode == 1) ? {1'b1, ready_busy_n_o, 6'h00} : (col < 4352) ? pbuf[col] : 8'hFF;
    if (mode != 1) col++;
  end
  always @(posedge pins_i.re_n) oe <= #25 1'b0;
  always @(posedge pins_i.cle or posedge pins_i.ale or posedge pins_i.ce_n or negedge pins_i.we_n) oe = 1'b0;
  // released bus must not keep showing the last byte
  always @(negedge oe) io_o = ~io_o;
endmodule : nfc_flash_model
`default_nettype wire

/* File: tb/nfc_host_test.sv */
// self-checking bench of the nand flash host controller
`default_nettype none
module nfc_host_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    nfc_pkg::nfc_op_t op;
    logic             p2;
    int               col;
    int               row;
    int               len;
    logic             bad;
  } nfc_case_t;
  logic                core_clk_i, rst_n_i, req_valid_i, wr_valid_i, slow;
  logic                req_ready_o, wr_ready_o, rd_valid_o, seg_end_o, done_o, err_o, ready_busy_n;
  logic [7:0]          wr_data_i, rd_data_o, status_o, dev_io, io_in, resets;
  nfc_pkg::nfc_req_t   req_i;
  nfc_pkg::nfc_pins_t  pins_o;
  logic [7:0]          em [int];
  int                  err_count, checks_done, i, k;
  nfc_case_t           cases [10] = '{
    '{nfc_pkg::OP_RESET, 0, 0, 0, 0, 0},
    '{nfc_pkg::OP_PROG, 0, 0, 'h40, 600, 0},
    '{nfc_pkg::OP_READ, 0, 0, 'h40, 600, 0},
    '{nfc_pkg::OP_ERASE, 0, 0, 'h40, 0, 0},
    '{nfc_pkg::OP_READ, 0, 0, 'h40, 16, 0},
    '{nfc_pkg::OP_PROG, 1, 4300, 'h41, 52, 0},
    '{nfc_pkg::OP_READ, 0, 4300, 'h41, 52, 0},
    '{nfc_pkg::OP_PROG, 0, 0, 'h42, 8, 0},
    '{nfc_pkg::OP_READ, 0, 0, 0, 4, 0},
    '{nfc_pkg::OP_STATUS, 0, 0, 0, 0, 0}};
  assign io_in = pins_o.io_oe ? pins_o.io : dev_io;
  nfc_host #(.PROG_CYC(200), .ERASE_CYC(1000), .RESET_CYC(200)) dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .wr_data_i(wr_data_i), .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .seg_end_o(seg_end_o), .status_o(status_o),
    .done_o(done_o), .err_o(err_o), .pins_o(pins_o), .io_in_i(io_in), .ready_busy_n_i(ready_busy_n));
  nfc_flash_model flash (.pins_i(pins_o), .slow_i(slow), .io_o(dev_io), .ready_busy_n_o(ready_busy_n),
    .resets_o(resets));
  // ==========
  // shared tasks
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  function automatic logic [7:0] ex(int r, int c);
    return em.exists(r * 8192 + c) ? em[r * 8192 + c] : 8'hFF;
  endfunction : ex
  // one whole operation; erow is the page the read data should come from
  task automatic run(nfc_case_t t, int erow);
    int   n, rn, j;
    logic fin, got_err, go, rd_op;
    @(posedge core_clk_i);
    #1;
    {n, rn, fin, got_err, go} = '0;
    rd_op = t.op inside {nfc_pkg::OP_READ, nfc_pkg::OP_RC_SEQ, nfc_pkg::OP_RC_END};
    req_i = '{t.op, t.p2, 13'(t.col), 19'(t.row), 13'(t.len)};
    req_valid_i = 1'b1;
    for (j = 0; j < 20000 && !fin; j++) begin
      @(posedge core_clk_i);
      if (req_valid_i && req_ready_o) go = 1'b1;
      if (wr_valid_i && wr_ready_o) begin
        em[t.row * 8192 + t.col + n] = ex(t.row, t.col + n) & wr_data_i;
        n++;
      end
      if (rd_valid_o && rd_op) begin
        check("read byte", ex(erow, t.col + rn), rd_data_o);
        check("segment end", {7'h0, rn % 512 == 511}, {7'h0, seg_end_o});
        rn++;
      end
      if (done_o || err_o) begin fin = 1'b1; got_err = err_o; end
      #1;
      req_valid_i = !go;
      wr_valid_i = go && !fin && n < t.len && t.op inside {nfc_pkg::OP_PROG, nfc_pkg::OP_PROG_CACHE};
      wr_data_i = 8'(t.row * 7 + t.col + n);
    end
    if (!fin) begin err_count++; stop_test(); end
    if (t.op == nfc_pkg::OP_ERASE) for (j = 0; j < 64 * 8192; j++) em.delete((t.row / 64) * 64 * 8192 + j);
    check("error flag", {7'h0, t.bad}, {7'h0, got_err});
  endtask : run
  // ==========
  // clock and main sequence
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  initial begin
    {rst_n_i, req_valid_i, wr_valid_i, slow, err_count, checks_done} = '0;
    wr_data_i = 8'h00;
    req_i = '0;
    repeat (16) @(posedge core_clk_i);
    #1;
    check("idle pins", 8'hE0, {pins_o.ce_n, pins_o.we_n, pins_o.re_n, pins_o.cle, pins_o.ale, pins_o.io_oe,
      req_ready_o, 1'b0});
    rst_n_i = 1'b1;
    @(posedge core_clk_i);
    #1;
    check("ready after reset", 8'h01, {7'h0, req_ready_o});
    foreach (cases[c]) run(cases[c], cases[c].row);
    // refused requests
    run('{nfc_pkg::OP_READ, 0, 4300, 'h41, 53, 1}, 'h41);
    run('{nfc_pkg::OP_PROG, 0, 0, 'h80, 0, 1}, 'h80);
    // fifth partial program of one page, then erase frees it
    for (i = 0; i < 5; i++) run('{nfc_pkg::OP_PROG, 0, i * 8, 'h80, 8, i == 4}, 'h80);
    run('{nfc_pkg::OP_ERASE, 0, 0, 'h80, 0, 0}, 'h80);
    run('{nfc_pkg::OP_PROG, 0, 0, 'h80, 8, 0}, 'h80);
    // cached read, other ops refused until the final read
    run('{nfc_pkg::OP_READ, 0, 4300, 'h41, 4, 0}, 'h41);
    run('{nfc_pkg::OP_RC_SEQ, 0, 0, 0, 8, 0}, 'h42);
    run('{nfc_pkg::OP_PROG, 0, 0, 'h46, 4, 1}, 'h46);
    run('{nfc_pkg::OP_RC_END, 0, 0, 0, 8, 0}, 'h43);
    // cache program left open needs status poll and reset first
    k = resets;
    run('{nfc_pkg::OP_PROG_CACHE, 0, 0, 'h44, 8, 0}, 'h44);
    run('{nfc_pkg::OP_STATUS, 0, 0, 0, 0, 0}, 0);
    check("reset count", 8'(k + 1), resets);
    check("status ready", 8'h40, status_o & 8'h40);
    run('{nfc_pkg::OP_READ, 0, 0, 'h44, 8, 0}, 'h44);
    // device too slow: busy timeout, then recovery by reset
    slow = 1'b1;
    run('{nfc_pkg::OP_PROG, 0, 0, 'h45, 4, 1}, 'h45);
    slow = 1'b0;
    run('{nfc_pkg::OP_RESET, 0, 0, 0, 0, 0}, 0);
    stop_test();
  end
endmodule : nfc_host_test
`default_nettype wire
